/* design/kmpg_defines.svh */
// Bit positions, reset values and sampling figures for the keyboard and mouse pin glue
`ifndef KMPG_DEFINES_SVH
`define KMPG_DEFINES_SVH

// Controller output port 2 bit positions
`define KMPG_P2_KBD_CLK 6
`define KMPG_P2_KBD_DAT 7
`define KMPG_P2_MS_CLK 3
`define KMPG_P2_MS_DAT 2
`define KMPG_P2_ADDR_GATE 1
`define KMPG_P2_KBD_RST 0

// Controller port 1 bit positions
`define KMPG_P1_KBD_DAT 0
`define KMPG_P1_MS_DAT 1
`define KMPG_P1_GP0 2
`define KMPG_P1_GP1 6
`define KMPG_P1_GP2 7

// Index of each sampled pin inside the synchroniser vector
`define KMPG_IDX_KBD_CLK 0
`define KMPG_IDX_KBD_DAT 1
`define KMPG_IDX_MS_CLK 2
`define KMPG_IDX_MS_DAT 3
`define KMPG_IDX_GP0 4
`define KMPG_IDX_GP1 5
`define KMPG_IDX_GP2 6

// Counts and widths
`define KMPG_LINK_PINS 4
`define KMPG_GP_PINS 3
`define KMPG_SYNC_PINS 7
`define KMPG_PORT_W 8

// Reset values
`define KMPG_PIN_IDLE 1'b1
`define KMPG_PIN_DRIVE 1'b0
`define KMPG_P1_RST 8'hFF
`define KMPG_WAKE_RST 4'h0

`endif

/* design/kmpg_pkg.sv */
// Types shared by the keyboard and mouse pin glue modules
`include "kmpg_defines.svh"

package kmpg_pkg;

    // Controller port image
    typedef logic [`KMPG_PORT_W-1:0] kmpg_port_t;

    // Wake-up vector, one bit per two-wire line
    typedef logic [`KMPG_LINK_PINS-1:0] kmpg_wake_t;

    // Whole registered state of the top module
    typedef struct packed {
        logic [`KMPG_LINK_PINS-1:0] link_oe;
        logic addr_gate_oe;
        logic kbd_rst_oe;
        logic [`KMPG_GP_PINS-1:0] gp_oe;
        logic drv_level;
        logic test0;
        logic test1;
        kmpg_port_t port1_in;
        kmpg_wake_t wake_pulse;
        kmpg_wake_t wake_sticky;
        logic wake_any;
    } kmpg_state_t;

endpackage : kmpg_pkg

/* design/kmpg_sync_if.sv */
// Interface between the top module and the pin synchroniser
interface kmpg_sync_if #(
    parameter int WIDTH = 7
);
    logic [WIDTH-1:0] pin_raw;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] activity;

    // Top module hands raw pins in and reads clean levels back
    modport user (
        output pin_raw,
        input level,
        input activity
    );

    // Synchroniser side
    modport sync (
        input pin_raw,
        output level,
        output activity
    );
endinterface : kmpg_sync_if

/* design/kmpg_pin_sync.sv */
// Two-stage synchroniser and edge finder for the sampled pins
`include "kmpg_defines.svh"
module kmpg_pin_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Pin levels in, clean levels and activity out
    kmpg_sync_if.sync sync_bus
);
    import kmpg_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } kmpg_sync_state_t;

    kmpg_sync_state_t state_ff;
    kmpg_sync_state_t nxt_state;

    // Shift chain; meta is read only by stable, never by the edge logic
    always_comb begin
        nxt_state = state_ff;
        nxt_state.meta = sync_bus.pin_raw;
        nxt_state.stable = state_ff.meta;
        nxt_state.prev = state_ff.stable;
    end

    // Lines idle high through their pull-ups, so reset to released
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            state_ff.meta <= {WIDTH{`KMPG_PIN_IDLE}};
            state_ff.stable <= {WIDTH{`KMPG_PIN_IDLE}};
            state_ff.prev <= {WIDTH{`KMPG_PIN_IDLE}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Any change of a clean level counts as activity for one cycle
    assign sync_bus.level = state_ff.stable;
    assign sync_bus.activity = state_ff.stable ^ state_ff.prev;

endmodule // kmpg_pin_sync

/* design/kmpg_glue.sv */
// Pin glue between the embedded keyboard and mouse controller and its external pins
`include "kmpg_defines.svh"

module kmpg_glue (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Controller output ports, same clock domain
    input wire kmpg_pkg::kmpg_port_t i_port2,
    input wire kmpg_pkg::kmpg_port_t i_port1_out,
    // Controller inputs fed back from the pins
    output logic o_test_input_zero,
    output logic o_test_input_one,
    output kmpg_pkg::kmpg_port_t o_port1_in,
    // Keyboard clock pin
    input wire logic i_keyboard_clock_pin,
    output logic o_keyboard_clock_pin,
    output logic o_keyboard_clock_pin_oe,
    // Keyboard data pin
    input wire logic i_keyboard_data_pin,
    output logic o_keyboard_data_pin,
    output logic o_keyboard_data_pin_oe,
    // Mouse clock pin
    input wire logic i_mouse_clock_pin,
    output logic o_mouse_clock_pin,
    output logic o_mouse_clock_pin_oe,
    // Mouse data pin
    input wire logic i_mouse_data_pin,
    output logic o_mouse_data_pin,
    output logic o_mouse_data_pin_oe,
    // Address line gate and keyboard reset, open-drain outputs
    output logic o_addr_line_gate_out,
    output logic o_addr_line_gate_out_oe,
    output logic o_keyboard_reset_out,
    output logic o_keyboard_reset_out_oe,
    // General-purpose pins on port 1 bits 2, 6, 7
    input wire logic [`KMPG_GP_PINS-1:0] i_gp_pin,
    output logic [`KMPG_GP_PINS-1:0] o_gp_pin,
    output logic [`KMPG_GP_PINS-1:0] o_gp_pin_oe,
    // Wake-up events
    input wire kmpg_pkg::kmpg_wake_t i_wake_en,
    input wire kmpg_pkg::kmpg_wake_t i_wake_clr,
    output kmpg_pkg::kmpg_wake_t o_wake_event,
    output kmpg_pkg::kmpg_wake_t o_wake_status,
    output logic o_wake_any
);
    import kmpg_pkg::*;

    // Open-drain convention for every pin of this block:
    // the data output is tied low and only the enable moves.
    // Enable high means the glue pulls the wire down; enable low
    // leaves the wire to its external pull-up resistor.
    // Never driving high means the glue cannot fight a keyboard
    // or mouse that holds the same wire low at that moment.
    // Limitation: the level seen back is the wired AND of both
    // sides, so firmware must release a line before it reads
    // what the far side is sending on it.

    // Whole registered state; every top-level output reads it
    kmpg_state_t state_ff;
    // Next value, filled by the single combinational process
    kmpg_state_t nxt_state;

    // Every pin is asynchronous to the core clock, so each one passes
    // two flip-flops before any logic reads it. The price is a three
    // cycle delay on each feedback path, far below any bit time of
    // the two-wire link, so the controller never notices it.
    // Pin synchroniser shared by the two-wire lines and general-purpose pins
    kmpg_sync_if #(.WIDTH(`KMPG_SYNC_PINS)) sync_bus ();

    kmpg_pin_sync #(
        .WIDTH(`KMPG_SYNC_PINS)
    ) u_pin_sync (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .sync_bus(sync_bus.sync)
    );

    // Raw pins enter the synchroniser; nothing else reads them.
    // Two-wire lines sit in the low part of the vector
    always_comb begin
        sync_bus.pin_raw[`KMPG_IDX_KBD_CLK] = i_keyboard_clock_pin;
        sync_bus.pin_raw[`KMPG_IDX_KBD_DAT] = i_keyboard_data_pin;
        sync_bus.pin_raw[`KMPG_IDX_MS_CLK] = i_mouse_clock_pin;
        sync_bus.pin_raw[`KMPG_IDX_MS_DAT] = i_mouse_data_pin;

        // General-purpose pins ride in the upper part
        sync_bus.pin_raw[`KMPG_IDX_GP0] = i_gp_pin[0];
        sync_bus.pin_raw[`KMPG_IDX_GP1] = i_gp_pin[1];
        sync_bus.pin_raw[`KMPG_IDX_GP2] = i_gp_pin[2];
    end

    // Open-drain enable for a pin whose level should equal the bit:
    // a one releases the pin to its pull-up, a zero pulls it low
    function automatic logic od_follow(input logic bit_val);
        od_follow = ~bit_val;
    endfunction

    // Open-drain enable for a two-wire line driven through an inverter:
    // the port bit itself is the pull request
    function automatic logic od_invert(input logic bit_val);
        od_invert = bit_val;
    endfunction

    // Next state. Drive enables follow the port bits after one edge,
    // which keeps every pin enable glitch free even while the
    // controller rewrites a whole port in one cycle
    always_comb begin
        nxt_state = state_ff;
        // Pin data stays low; only the enables below move
        nxt_state.drv_level = `KMPG_PIN_DRIVE;

        // Keyboard and mouse lines: a one in the port bit pulls low
        nxt_state.link_oe[`KMPG_IDX_KBD_CLK] = od_invert(i_port2[`KMPG_P2_KBD_CLK]);
        nxt_state.link_oe[`KMPG_IDX_KBD_DAT] = od_invert(i_port2[`KMPG_P2_KBD_DAT]);
        nxt_state.link_oe[`KMPG_IDX_MS_CLK] = od_invert(i_port2[`KMPG_P2_MS_CLK]);
        nxt_state.link_oe[`KMPG_IDX_MS_DAT] = od_invert(i_port2[`KMPG_P2_MS_DAT]);

        // Gate and reset outputs are not inverted: a zero bit pulls low
        nxt_state.addr_gate_oe = od_follow(i_port2[`KMPG_P2_ADDR_GATE]);
        nxt_state.kbd_rst_oe = od_follow(i_port2[`KMPG_P2_KBD_RST]);

        // General-purpose pins: firmware writes a one to release before sampling
        nxt_state.gp_oe[0] = od_follow(i_port1_out[`KMPG_P1_GP0]);
        nxt_state.gp_oe[1] = od_follow(i_port1_out[`KMPG_P1_GP1]);
        nxt_state.gp_oe[2] = od_follow(i_port1_out[`KMPG_P1_GP2]);

        // Pin levels back to the controller inputs; unwired bits read released
        nxt_state.test0 = sync_bus.level[`KMPG_IDX_KBD_CLK];
        nxt_state.test1 = sync_bus.level[`KMPG_IDX_MS_CLK];
        nxt_state.port1_in = `KMPG_P1_RST;
        nxt_state.port1_in[`KMPG_P1_KBD_DAT] = sync_bus.level[`KMPG_IDX_KBD_DAT];
        nxt_state.port1_in[`KMPG_P1_MS_DAT] = sync_bus.level[`KMPG_IDX_MS_DAT];
        nxt_state.port1_in[`KMPG_P1_GP0] = sync_bus.level[`KMPG_IDX_GP0];
        nxt_state.port1_in[`KMPG_P1_GP1] = sync_bus.level[`KMPG_IDX_GP1];
        nxt_state.port1_in[`KMPG_P1_GP2] = sync_bus.level[`KMPG_IDX_GP2];

        // Wake-up: any edge on an enabled line, including our own drive, counts.
        // Limitation: a glitch shorter than one core clock may fall between
        // samples and be missed; real link edges last far longer.
        nxt_state.wake_pulse = sync_bus.activity[`KMPG_LINK_PINS-1:0] & i_wake_en;
        // A new event in the clearing cycle survives the clear,
        // so no edge is ever lost to a late clear; status holds until cleared
        nxt_state.wake_sticky = (state_ff.wake_sticky & ~i_wake_clr) | nxt_state.wake_pulse;
        nxt_state.wake_any = |nxt_state.wake_sticky;
    end

    // State register with synchronous reset.
    // Reset leaves every pin released and the feedback bits high,
    // matching what the idle pulled-up wires will show
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            // No pin pulled
            state_ff.link_oe <= '0;
            state_ff.addr_gate_oe <= 1'b0;
            state_ff.kbd_rst_oe <= 1'b0;
            state_ff.gp_oe <= '0;
            state_ff.drv_level <= `KMPG_PIN_DRIVE;
            // Feedback reads released
            state_ff.test0 <= `KMPG_PIN_IDLE;
            state_ff.test1 <= `KMPG_PIN_IDLE;
            state_ff.port1_in <= `KMPG_P1_RST;
            // No pending wake-up
            state_ff.wake_pulse <= `KMPG_WAKE_RST;
            state_ff.wake_sticky <= `KMPG_WAKE_RST;
            state_ff.wake_any <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Pin outputs only ever drive low; the enable decides pull or release.
    // Data and enable come from flip-flops, so no combinational path
    // runs from any input to a pin.

    // Keyboard clock pin
    assign o_keyboard_clock_pin = state_ff.drv_level;
    assign o_keyboard_clock_pin_oe = state_ff.link_oe[`KMPG_IDX_KBD_CLK];

    // Keyboard data pin
    assign o_keyboard_data_pin = state_ff.drv_level;
    assign o_keyboard_data_pin_oe = state_ff.link_oe[`KMPG_IDX_KBD_DAT];

    // Mouse clock pin
    assign o_mouse_clock_pin = state_ff.drv_level;
    assign o_mouse_clock_pin_oe = state_ff.link_oe[`KMPG_IDX_MS_CLK];

    // Mouse data pin
    assign o_mouse_data_pin = state_ff.drv_level;
    assign o_mouse_data_pin_oe = state_ff.link_oe[`KMPG_IDX_MS_DAT];

    // Address line gate pin, level equals the port bit
    assign o_addr_line_gate_out = state_ff.drv_level;
    assign o_addr_line_gate_out_oe = state_ff.addr_gate_oe;

    // Keyboard reset pin, level equals the port bit
    assign o_keyboard_reset_out = state_ff.drv_level;
    assign o_keyboard_reset_out_oe = state_ff.kbd_rst_oe;

    // General-purpose pins on port 1 bits 2, 6, 7
    assign o_gp_pin = {`KMPG_GP_PINS{state_ff.drv_level}};
    assign o_gp_pin_oe = state_ff.gp_oe;

    // Controller feedback: pin levels after synchronisation
    assign o_test_input_zero = state_ff.test0;
    assign o_test_input_one = state_ff.test1;
    assign o_port1_in = state_ff.port1_in;

    // Wake-up outputs; the summary bit shares the cycle of the status
    assign o_wake_event = state_ff.wake_pulse;
    assign o_wake_status = state_ff.wake_sticky;
    assign o_wake_any = state_ff.wake_any;

endmodule // kmpg_glue

/* sim/kmpg_glue_properties.sv */
// Checker of the pin glue port relations
module kmpg_glue_properties (
    // Clock, reset and controller ports
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire kmpg_pkg::kmpg_port_t i_port2,
    input wire kmpg_pkg::kmpg_port_t i_port1_out,
    // Pins and feedback
    input wire logic i_keyboard_clock_pin,
    input wire logic i_mouse_data_pin,
    input wire logic o_test_input_zero,
    input wire logic o_keyboard_clock_pin_oe,
    input wire logic o_keyboard_data_pin_oe,
    input wire logic o_mouse_clock_pin_oe,
    input wire logic o_mouse_data_pin_oe,
    input wire logic o_addr_line_gate_out_oe,
    input wire logic o_keyboard_reset_out_oe,
    input wire logic [2:0] o_gp_pin_oe,
    // Wake-up
    input wire kmpg_pkg::kmpg_wake_t i_wake_en,
    input wire kmpg_pkg::kmpg_wake_t o_wake_event,
    input wire kmpg_pkg::kmpg_wake_t o_wake_status
);
    timeunit 1ns;
    timeprecision 1ps;
    import kmpg_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // Drive paths: exactly one edge from port bit to enable
    property p_kclk; 1 |=> o_keyboard_clock_pin_oe == $past(i_port2[6]); endproperty
    a_kclk: assert property (p_kclk) else $error("kclk oe wrong");
    property p_kdat; 1 |=> o_keyboard_data_pin_oe == $past(i_port2[7]); endproperty
    a_kdat: assert property (p_kdat) else $error("kdat oe wrong");
    property p_mclk; 1 |=> o_mouse_clock_pin_oe == $past(i_port2[3]); endproperty
    a_mclk: assert property (p_mclk) else $error("mclk oe wrong");
    property p_mouse_data_pin; 1 |=> o_mouse_data_pin_oe == $past(i_port2[2]); endproperty
    a_mouse_data_pin: assert property (p_mouse_data_pin) else $error("mouse_data_pin oe wrong");
    // Gate and reset pins are not inverted: a one releases them
    property p_gate; 1 |=> o_addr_line_gate_out_oe != $past(i_port2[1]); endproperty
    a_gate: assert property (p_gate) else $error("gate oe wrong");
    property p_krst; 1 |=> o_keyboard_reset_out_oe != $past(i_port2[0]); endproperty
    a_krst: assert property (p_krst) else $error("reset oe wrong");
    property p_gp;
        1 |=> o_gp_pin_oe == ~{$past(i_port1_out[7]), $past(i_port1_out[6]), $past(i_port1_out[2])};
    endproperty
    a_gp: assert property (p_gp) else $error("gp oe wrong");
    // Pin low on two samples shows at test input zero three edges after the first
    property p_t0;
        $fell(i_keyboard_clock_pin) ##1 !i_keyboard_clock_pin |=> ##1 !o_test_input_zero;
    endproperty
    a_t0: assert property (p_t0) else $error("test input zero late");
    // Enabled mouse data fall: event and status stand three edges after the first low sample
    property p_wake;
        ($fell(i_mouse_data_pin) && i_wake_en[3]) ##1 (!i_mouse_data_pin && i_wake_en[3]) ##1 i_wake_en[3]
            |=> o_wake_event[3] && o_wake_status[3];
    endproperty
    a_wake: assert property (p_wake) else $error("mouse_data_pin wake missing");
    c_ev: cover property (o_wake_event[0]);
    c_clr: cover property (o_wake_status[0] ##1 !o_wake_status[0]);
    c_fb: cover property ($fell(o_test_input_zero));
endmodule // kmpg_glue_properties

bind kmpg_glue kmpg_glue_properties chk_u (.*);

/* sim/kmpg_link_partner.sv */
// Far-side keyboard and mouse model with the line pull-ups
module kmpg_link_partner (
    // Bench controls: static pulls and a keyboard clock burst
    input wire logic [3:0] i_hold,
    input wire logic i_frame,
    // Glue pull enables, index 0 kclk, 1 kdat, 2 mclk, 3 mouse_data_pin
    input wire logic [3:0] i_oe,
    // Resolved wire levels
    output logic [3:0] o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_low = 1'b0;
    // Keyboard clock stands high between frames, 125 ns period inside one
    initial begin
        forever begin
            @(posedge i_frame);
            repeat (4) begin
                #62.5 clk_low = 1'b1;
                #62.5 clk_low = 1'b0;
            end
        end
    end
    // Open-drain: low while either side pulls, else the pull-up wins
    assign o_line = ~(i_oe | i_hold | {3'b000, clk_low});
endmodule // kmpg_link_partner

/* sim/tb_top.sv */
// Self-checking bench for the keyboard and mouse pin glue
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import kmpg_pkg::*;
    logic i_core_clk, i_nrst, t0, t1, w_any, frame, g_oe, r_oe;
    kmpg_port_t p2, p1, p1in;
    logic [3:0] hold, oe, line;
    logic [2:0] gp_oe;
    logic [8:0] drv;
    kmpg_wake_t wen, wclr, wev, wst;
    int fails = 0, n_tests = 0, cyc = 0;
    kmpg_glue dut_u (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_port2(p2), .i_port1_out(p1),
        .o_test_input_zero(t0), .o_test_input_one(t1), .o_port1_in(p1in),
        .i_keyboard_clock_pin(line[0]), .o_keyboard_clock_pin(drv[0]), .o_keyboard_clock_pin_oe(oe[0]),
        .i_keyboard_data_pin(line[1]), .o_keyboard_data_pin(drv[1]), .o_keyboard_data_pin_oe(oe[1]),
        .i_mouse_clock_pin(line[2]), .o_mouse_clock_pin(drv[2]), .o_mouse_clock_pin_oe(oe[2]),
        .i_mouse_data_pin(line[3]), .o_mouse_data_pin(drv[3]), .o_mouse_data_pin_oe(oe[3]),
        .o_addr_line_gate_out(drv[4]), .o_addr_line_gate_out_oe(g_oe),
        .o_keyboard_reset_out(drv[5]), .o_keyboard_reset_out_oe(r_oe),
        .i_gp_pin(~gp_oe), .o_gp_pin(drv[8:6]), .o_gp_pin_oe(gp_oe), .i_wake_en(wen), .i_wake_clr(wclr),
        .o_wake_event(wev), .o_wake_status(wst), .o_wake_any(w_any));
    kmpg_link_partner link_u (.i_hold(hold), .i_frame(frame), .i_oe(oe), .o_line(line));
    // Core clock, 10 ns
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // Hang guard, far above the 130 or so cycles needed
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Inputs move 1 ns after the edge, so outputs are settled there too
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // Each port 2 bit alone, then all, reaches its pin one edge later
    task automatic t_drive();
        for (int k = 0; k < 9; k++) begin
            p2 = (k < 8) ? 8'h01 << k : 8'hFF;
            tick(1);
            chk({oe, line}, {p2[2], p2[3], p2[7], p2[6], ~p2[2], ~p2[3], ~p2[7], ~p2[6]});
            chk({g_oe, r_oe, drv}, {~p2[1], ~p2[0], 9'h000});
        end
        p2 = 8'h00;
    endtask
    // Spare pins follow port 1 and read back four edges later
    task automatic t_gp();
        for (int k = 0; k < 8; k++) begin
            p1 = {k[2], k[1], 3'b000, k[0], 2'b00};
            tick(4);
            chk({gp_oe, p1in[7:2]}, {~k[2], ~k[1], ~k[0], k[2], k[1], 3'b111, k[0]});
        end
    endtask
    // Far-side pulls show at the feedback bits three edges later
    task automatic t_read();
        for (int k = 0; k < 5; k++) begin
            hold = (k < 4) ? 4'h1 << k : 4'h0;
            tick(3);
            chk({p1in[1], t1, p1in[0], t0, wst}, {~hold, 4'h0});
        end
    endtask
    // Link traffic and own drive set sticky status; clear drops it
    task automatic t_wake();
        wen = 4'hF;
        frame = 1'b1;
        tick(60);
        chk({wst, w_any}, 5'h03);
        frame = 1'b0;
        wclr = 4'hF;
        tick(1);
        wclr = 4'h0;
        chk({wst, w_any}, 5'h00);
        p2 = 8'h04;
        tick(4);
        chk({wev, wst}, 8'h88);
        tick(1);
        chk({wev, wst}, 8'h08);
        p2 = 8'h00;
        wen = 4'h0;
        tick(4);
        chk({wev, wst}, 8'h08);
    endtask
    initial begin
        i_nrst = 1'b0;
        p2 = 8'h00;
        p1 = 8'h00;
        hold = 4'h0;
        frame = 1'b0;
        wen = 4'h0;
        wclr = 4'h0;
        tick(4);
        i_nrst = 1'b1;
        chk({oe, g_oe, r_oe, gp_oe, t0, t1, p1in, wst, w_any}, {9'h000, 2'b11, 8'hFF, 5'h00});
        t_drive();
        t_gp();
        t_read();
        t_wake();
        stop_test();
    end
endmodule // tb_top
